//--- pvt_pkg.sv
// Package of constants, register map and carrier types for the interval timer
package pvt_pkg;

   // Register bus geometry
   localparam int unsigned PVT_ADDR_W = 8;
   localparam int unsigned PVT_DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_MODE       = 8'h00;
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_STATUS     = 8'h04;
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_VALUE_ACK  = 8'h08;
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_VALUE_PEEK = 8'h0c;
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_EVT_STATUS = 8'h10;
   localparam logic [PVT_ADDR_W-1:0] PVT_OFS_EVT_MASK   = 8'h14;

   // Counter widths
   localparam int unsigned PVT_LIMIT_W   = 20;
   localparam int unsigned PVT_ELAPSED_W = 12;

   // Field positions
   localparam int unsigned PVT_LIMIT_LSB     = 0;
   localparam int unsigned PVT_TIMER_EN_BIT  = 24;
   localparam int unsigned PVT_IRQ_EN_BIT    = 25;
   localparam int unsigned PVT_FLAG_BIT      = 0;
   localparam int unsigned PVT_CURRENT_LSB   = 0;
   localparam int unsigned PVT_ELAPSED_LSB   = 20;

   // Event bits of the sticky event status and mask registers
   localparam int unsigned PVT_EVT_W        = 2;
   localparam int unsigned PVT_EVT_INTERVAL = 0;
   localparam int unsigned PVT_EVT_WRAP     = 1;

   // Reset values
   localparam logic [PVT_DATA_W-1:0]    PVT_MODE_RESET      = 32'h000f_ffff;
   localparam logic [PVT_LIMIT_W-1:0]   PVT_LIMIT_RESET     = 20'hf_ffff;
   localparam logic [PVT_LIMIT_W-1:0]   PVT_CURRENT_RESET   = 20'h0_0000;
   localparam logic [PVT_ELAPSED_W-1:0] PVT_ELAPSED_RESET   = 12'h000;
   localparam logic [PVT_ELAPSED_W-1:0] PVT_ELAPSED_MAX     = 12'hfff;
   localparam logic [PVT_EVT_W-1:0]     PVT_EVT_RESET       = 2'h0;
   localparam logic [PVT_DATA_W-1:0]    PVT_RDATA_RESET     = 32'h0000_0000;

   // Tick prescaler: master clock divided by sixteen
   localparam int unsigned          PVT_PRESCALE_DIV = 16;
   localparam int unsigned          PVT_PRESCALE_W   = 4;
   localparam logic [PVT_PRESCALE_W-1:0] PVT_PRESCALE_LAST =
      PVT_PRESCALE_W'(PVT_PRESCALE_DIV - 1);

   // Effective run state of the interval counter
   typedef enum logic [0:0] {
      PVT_STOPPED = 1'b0,
      PVT_RUNNING = 1'b1
   } pvt_run_t;

   // Register bus request
   typedef struct packed {
      logic [PVT_ADDR_W-1:0] addr;
      logic [PVT_DATA_W-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } pvt_bus_req_t;

   // Prescaler state
   typedef struct packed {
      logic [PVT_PRESCALE_W-1:0] count;
      logic                      tick;
   } pvt_tick_state_t;

   // Timer core state
   typedef struct packed {
      logic [PVT_LIMIT_W-1:0]   cur_count;
      logic [PVT_ELAPSED_W-1:0] elapsed;
      logic                     flag;
      logic [PVT_LIMIT_W-1:0]   limit;
      logic                     en_bit;
      logic                     irq_en;
      pvt_run_t                 run;
      logic [PVT_EVT_W-1:0]     evt_status;
      logic [PVT_EVT_W-1:0]     evt_mask;
      logic [PVT_DATA_W-1:0]    rd_data;
      logic                     irq;
   } pvt_state_t;

endpackage

//--- pvt_tick_gen.sv
// Divide-by-sixteen tick enable for the interval counters
module pvt_tick_gen
   import pvt_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic hold,
   output logic      tick
);

   pvt_tick_state_t s_q;
   pvt_tick_state_t s_d;

   // Divider freezes with the counters so a halted period resumes exactly
   always_comb
   begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!hold)
      begin
         if (s_q.count == PVT_PRESCALE_LAST)
         begin
            s_d.count = '0;
            s_d.tick  = 1'b1;
         end
         else
         begin
            s_d.count = s_q.count + PVT_PRESCALE_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule

//--- pvt_timer.sv
// Periodic interval timer: counters, register slave and interrupt
//
// Overview of operation
// - 20 and 12-bit counters ticked at clock/16
// - Count up from zero, wrap, bump elapsed
// - Limit hit sets flag; irq when enabled
// - Period is limit plus one ticks
// - Mode writes never disturb running counters
// - Ack read returns counts, clears elapsed, flag
// - Peek read returns counts without side effects
// - Enable resets low, acts only at zero
// - Disabled counter finishes period, parks at zero
// - Debug state freezes both counters
// - Elapsed in 31:20, current in 19:0
// - Enable bit 24, irq enable 25, limit ones
//
// Design decision made here: the address-and-strobe port.
module pvt_timer
   import pvt_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire pvt_bus_req_t          bus_req,
   output logic [PVT_DATA_W-1:0]      rd_data,
   input  wire logic                  core_debug_halt,
   output logic                       irq
);

   pvt_state_t               s_q;
   pvt_state_t               s_d;

   logic                     tick;
   logic                     advance;
   logic                     at_limit;
   logic                     complete;
   logic                     elapsed_wrap;
   logic                     ack_read;
   logic                     mode_write;
   logic                     evt_clear_write;
   logic                     mask_write;
   logic [PVT_EVT_W-1:0]     evt_set;
   logic [PVT_DATA_W-1:0]    count_word;
   logic [PVT_DATA_W-1:0]    mode_word;
   logic [PVT_DATA_W-1:0]    read_word;

   // Tick enable; held in debug so the fraction of a tick is kept
   pvt_tick_gen u_tick_gen
   (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .hold    (core_debug_halt),
      .tick    (tick)
   );

   // Bus decode
   always_comb
   begin
      ack_read        = bus_req.rd && (bus_req.addr == PVT_OFS_VALUE_ACK);
      mode_write      = bus_req.wr && (bus_req.addr == PVT_OFS_MODE);
      evt_clear_write = bus_req.wr && (bus_req.addr == PVT_OFS_EVT_STATUS);
      mask_write      = bus_req.wr && (bus_req.addr == PVT_OFS_EVT_MASK);
   end

   // Counter advance conditions
   always_comb
   begin
      advance      = tick && !core_debug_halt && (s_q.run == PVT_RUNNING);
      // Full 20-bit equality; a limit lowered below the count waits for rollover
      at_limit     = (s_q.cur_count == s_q.limit);
      complete     = advance && at_limit;
      elapsed_wrap = complete && (s_q.elapsed == PVT_ELAPSED_MAX);
   end

   // Readback words
   always_comb
   begin
      count_word = '0;
      count_word[PVT_ELAPSED_LSB +: PVT_ELAPSED_W] = s_q.elapsed;
      count_word[PVT_CURRENT_LSB +: PVT_LIMIT_W]   = s_q.cur_count;
   end

   always_comb
   begin
      mode_word = '0;
      mode_word[PVT_LIMIT_LSB +: PVT_LIMIT_W] = s_q.limit;
      mode_word[PVT_TIMER_EN_BIT]             = s_q.en_bit;
      mode_word[PVT_IRQ_EN_BIT]               = s_q.irq_en;
   end

   // Read multiplexer; unmapped offsets read as zero
   always_comb
   begin
      read_word = '0;
      unique case (bus_req.addr)
         PVT_OFS_MODE:
         begin
            read_word = mode_word;
         end
         PVT_OFS_STATUS:
         begin
            read_word[PVT_FLAG_BIT] = s_q.flag;
         end
         PVT_OFS_VALUE_ACK:
         begin
            read_word = count_word;
         end
         PVT_OFS_VALUE_PEEK:
         begin
            read_word = count_word;
         end
         PVT_OFS_EVT_STATUS:
         begin
            read_word[PVT_EVT_W-1:0] = s_q.evt_status;
         end
         PVT_OFS_EVT_MASK:
         begin
            read_word[PVT_EVT_W-1:0] = s_q.evt_mask;
         end
         default:
         begin
            read_word = '0;
         end
      endcase
   end

   // Events feeding the sticky event status
   always_comb
   begin
      evt_set                   = '0;
      evt_set[PVT_EVT_INTERVAL] = complete;
      evt_set[PVT_EVT_WRAP]     = elapsed_wrap;
   end

   // Next-state logic
   always_comb
   begin
      s_d = s_q;

      // Effective enable is sampled only while the counter sits at zero
      if (s_q.cur_count == PVT_CURRENT_RESET)
      begin
         unique case (s_q.run)
            PVT_STOPPED:
            begin
               if (s_q.en_bit)
               begin
                  s_d.run = PVT_RUNNING;
               end
            end
            PVT_RUNNING:
            begin
               // A tick here would leave the count stranded at one
               if (!s_q.en_bit && !advance)
               begin
                  s_d.run = PVT_STOPPED;
               end
            end
         endcase
      end

      // Interval counter; once running it finishes the period regardless
      if (advance)
      begin
         if (at_limit)
         begin
            s_d.cur_count = PVT_CURRENT_RESET;
         end
         else
         begin
            s_d.cur_count = s_q.cur_count + PVT_LIMIT_W'(1);
         end
      end

      // Elapsed count and flag: an ack read clears, a completion wins
      if (ack_read)
      begin
         s_d.elapsed = PVT_ELAPSED_RESET;
         s_d.flag    = 1'b0;
      end
      if (complete)
      begin
         if (ack_read)
         begin
            s_d.elapsed = PVT_ELAPSED_RESET + PVT_ELAPSED_W'(1);
         end
         else
         begin
            s_d.elapsed = s_q.elapsed + PVT_ELAPSED_W'(1);
         end
         s_d.flag = 1'b1;
      end

      // Mode write touches only configuration, never the counters
      if (mode_write)
      begin
         s_d.limit  = bus_req.wdata[PVT_LIMIT_LSB +: PVT_LIMIT_W];
         s_d.en_bit = bus_req.wdata[PVT_TIMER_EN_BIT];
         s_d.irq_en = bus_req.wdata[PVT_IRQ_EN_BIT];
      end

      // Sticky events: write one to clear, a new event wins
      if (evt_clear_write)
      begin
         s_d.evt_status = s_q.evt_status & ~bus_req.wdata[PVT_EVT_W-1:0];
      end
      s_d.evt_status = s_d.evt_status | evt_set;

      if (mask_write)
      begin
         s_d.evt_mask = bus_req.wdata[PVT_EVT_W-1:0];
      end

      // Read data stands for exactly one cycle
      if (bus_req.rd)
      begin
         s_d.rd_data = read_word;
      end
      else
      begin
         s_d.rd_data = PVT_RDATA_RESET;
      end

      // Registered interrupt from next flag and irq enable, or from next sticky events under the mask
      s_d.irq = (s_d.flag && s_d.irq_en) || (|(s_d.evt_status & s_d.evt_mask));
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q.cur_count  <= PVT_CURRENT_RESET;
         s_q.elapsed    <= PVT_ELAPSED_RESET;
         s_q.flag       <= 1'b0;
         s_q.limit      <= PVT_LIMIT_RESET;
         s_q.en_bit     <= 1'b0;
         s_q.irq_en     <= 1'b0;
         s_q.run        <= PVT_STOPPED;
         s_q.evt_status <= PVT_EVT_RESET;
         s_q.evt_mask   <= PVT_EVT_RESET;
         s_q.rd_data    <= PVT_RDATA_RESET;
         s_q.irq        <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd_data;
   assign irq     = s_q.irq;

endmodule

//--- pvt_timer_properties.sv
// Bus and interrupt timing checker bound to the interval timer
module pvt_timer_properties
   import pvt_pkg::*;
(
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire pvt_bus_req_t          bus_req,
   input wire logic [PVT_DATA_W-1:0] rd_data,
   input wire logic                  core_debug_halt,
   input wire logic                  irq
);
   logic [31:0] mode_q;
   logic [1:0]  mask_q;
   logic        peek_h;
   logic        ack_h;
   logic        src;
   logic [19:0] cur_f;
   // Halted reads only, so the counters cannot move in between
   assign peek_h = bus_req.rd && bus_req.addr == PVT_OFS_VALUE_PEEK && core_debug_halt;
   assign ack_h  = bus_req.rd && bus_req.addr == PVT_OFS_VALUE_ACK && core_debug_halt;
   assign src    = mode_q[25] || mask_q != 2'h0;
   assign cur_f  = rd_data[19:0];
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= PVT_MODE_RESET;
         mask_q <= 2'h0;
      end
      else if (bus_req.wr && bus_req.addr == PVT_OFS_MODE)
         mode_q <= bus_req.wdata & 32'h030f_ffff;
      else if (bus_req.wr && bus_req.addr == PVT_OFS_EVT_MASK)
         mask_q <= bus_req.wdata[1:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_rdata_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_mode_readback: assert property (bus_req.rd && bus_req.addr == PVT_OFS_MODE |=> rd_data == $past(mode_q))
      else $error("mode read differs from last write");
   a_irq_needs_en: assert property (irq |-> src || $past(src))
      else $error("interrupt without an enabled source");
   a_halt_freezes: assert property (peek_h ##1 peek_h |=> rd_data == $past(rd_data))
      else $error("counters moved while halted");
   a_peek_no_clear: assert property (peek_h ##1 ack_h |=> rd_data == $past(rd_data))
      else $error("peek read disturbed the counters");
   a_ack_clears: assert property (ack_h ##1 peek_h |=> rd_data[31:20] == 12'h000 && cur_f == $past(cur_f))
      else $error("ack read did not clear elapsed only");
   a_mode_keeps_count: assert property (peek_h ##1 (bus_req.wr && bus_req.addr == PVT_OFS_MODE && core_debug_halt)
      ##1 peek_h |=> rd_data == $past(rd_data, 2))
      else $error("mode write changed the counters");
   a_ack_drops_irq: assert property (ack_h && mask_q == 2'h0 |=> !irq)
      else $error("interrupt stayed after ack read");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > PVT_OFS_EVT_MASK |=> rd_data == 32'h0)
      else $error("unmapped read returned data");
endmodule
bind pvt_timer pvt_timer_properties chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
   .rd_data(rd_data), .core_debug_halt(core_debug_halt), .irq(irq));

//--- pvt_timer_tb.sv
// Self-checking bench for the interval timer registers and interrupt
module pvt_timer_tb
   import pvt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  ref_clk;
   logic                  rst_n;
   logic                  halt;
   logic                  irq;
   pvt_bus_req_t          req;
   logic [PVT_DATA_W-1:0] rdata;
   logic [7:0]            ba [$];
   logic [31:0]           bd [$];
   logic                  bw [$];
   logic [31:0]           bq [8];
   logic [31:0]           v;
   int                    errors = 0;
   int                    num_checks = 0;
   int                    cyc = 0;
   int                    t0;
   int                    t1;

   pvt_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req), .rd_data(rdata),
      .core_debug_halt(halt), .irq(irq));

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   task automatic put(input logic w, input logic [7:0] a, input logic [31:0] d);
      ba.push_back(a);
      bd.push_back(d);
      bw.push_back(w);
   endtask
   // Back-to-back accesses; answer of access i lands in bq[i]
   task automatic burst();
      for (int i = 0; i <= ba.size(); i++)
      begin
         if (i < ba.size())
            req <= '{ba[i], bd[i], bw[i], !bw[i]};
         else
            req <= '0;
         @(posedge ref_clk);
         if (i > 0)
            bq[i-1] = rdata;
      end
      ba.delete();
      bd.delete();
      bw.delete();
   endtask
   task automatic rd1(input logic [7:0] a);
      put(1'b0, a, 32'h0);
      burst();
   endtask
   task automatic wr1(input logic [7:0] a, input logic [31:0] d);
      put(1'b1, a, d);
      burst();
   endtask
   task automatic wait_irq(output int t);
      repeat (2000)
      begin
         if (irq === 1'b1)
            break;
         @(posedge ref_clk);
      end
      chk("irq wait", 32'h1, 32'(irq));
      t = cyc;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Whole run needs about 67000 cycles, mostly the elapsed wrap
   initial
   begin
      #900000;
      errors++;
      end_sim();
   end

   initial
   begin
      rst_n = 1'b0;
      halt = 1'b0;
      req = '0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      put(1'b0, PVT_OFS_MODE, 32'h0);
      put(1'b0, PVT_OFS_STATUS, 32'h0);
      put(1'b0, PVT_OFS_VALUE_ACK, 32'h0);
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      put(1'b0, 8'h20, 32'h0);
      burst();
      chk("mode reset", PVT_MODE_RESET, bq[0]);
      for (int i = 1; i < 5; i++)
         chk("reset read", 32'h0, bq[i]);
      wr1(PVT_OFS_MODE, 32'h0300_0003);
      rd1(PVT_OFS_MODE);
      chk("mode", 32'h0300_0003, bq[0]);
      wait_irq(t0);
      rd1(PVT_OFS_VALUE_ACK);
      wait_irq(t1);
      chk("period", 32'd64, 32'(t1 - t0));
      rd1(PVT_OFS_STATUS);
      chk("status", 32'h1, bq[0]);
      rd1(PVT_OFS_VALUE_ACK);
      repeat (216) @(posedge ref_clk);
      halt <= 1'b1;
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      put(1'b0, PVT_OFS_VALUE_ACK, 32'h0);
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      burst();
      chk("elapsed", 32'd3, 32'(bq[0][31:20]));
      chk("peek then ack", bq[0], bq[1]);
      chk("after ack", {12'h000, bq[1][19:0]}, bq[2]);
      rd1(PVT_OFS_STATUS);
      chk("status cleared", 32'h0, bq[0]);
      chk("irq cleared", 32'h0, 32'(irq));
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      put(1'b1, PVT_OFS_MODE, 32'h0300_0007);
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      put(1'b0, PVT_OFS_VALUE_PEEK, 32'h0);
      burst();
      chk("mode write", bq[0], bq[2]);
      v = bq[3];
      repeat (100) @(posedge ref_clk);
      rd1(PVT_OFS_VALUE_PEEK);
      chk("frozen", v, bq[0]);
      halt <= 1'b0;
      wr1(PVT_OFS_MODE, 32'h0100_0007);
      repeat (300) @(posedge ref_clk);
      rd1(PVT_OFS_STATUS);
      chk("masked status", 32'h1, bq[0]);
      chk("masked irq", 32'h0, 32'(irq));
      wr1(PVT_OFS_EVT_MASK, 32'h1);
      halt <= 1'b1;
      rd1(PVT_OFS_EVT_STATUS);
      chk("event bit", 32'h1, 32'(bq[0][0]));
      chk("event irq", 32'h1, 32'(irq));
      wr1(PVT_OFS_EVT_STATUS, 32'h3);
      rd1(PVT_OFS_EVT_STATUS);
      chk("event clear", 32'h0, bq[0]);
      chk("event irq off", 32'h0, 32'(irq));
      wr1(PVT_OFS_EVT_MASK, 32'h0);
      halt <= 1'b0;
      // Disable lets the period finish, then the count parks at zero
      wr1(PVT_OFS_MODE, 32'h0000_0007);
      repeat (300) @(posedge ref_clk);
      rd1(PVT_OFS_VALUE_PEEK);
      chk("parked", 32'h0, 32'(bq[0][19:0]));
      // Limit zero completes on every tick; about 4100 ticks wrap the elapsed count
      rd1(PVT_OFS_VALUE_ACK);
      wr1(PVT_OFS_EVT_STATUS, 32'h3);
      wr1(PVT_OFS_MODE, 32'h0100_0000);
      repeat (65600) @(posedge ref_clk);
      wr1(PVT_OFS_MODE, 32'h0000_0000);
      rd1(PVT_OFS_EVT_STATUS);
      chk("wrap event", 32'h2, bq[0] & 32'h2);
      rd1(PVT_OFS_VALUE_PEEK);
      chk("elapsed wrapped", 32'h1, 32'(bq[0][31:20] < 12'h008));
      wr1(PVT_OFS_MODE, 32'h0100_0007);
      repeat (50) @(posedge ref_clk);
      rd1(PVT_OFS_VALUE_PEEK);
      chk("restart", 32'h1, 32'(bq[0][19:0] != 20'h0));
      // Ack read landing on a completion keeps the new interval
      halt <= 1'b1;
      rd1(PVT_OFS_VALUE_ACK);
      wr1(PVT_OFS_MODE, 32'h0300_0007);
      halt <= 1'b0;
      wait_irq(t0);
      repeat (126) @(posedge ref_clk);
      rd1(PVT_OFS_VALUE_ACK);
      chk("ack at wrap", 32'h0010_0007, bq[0]);
      rd1(PVT_OFS_STATUS);
      chk("flag kept", 32'h1, bq[0]);
      rd1(PVT_OFS_VALUE_PEEK);
      chk("elapsed kept", 32'h1, 32'(bq[0][31:20]));
      end_sim();
   end
endmodule
